// *** common/e1rpc_pkg.sv ***
// Constants, field layout and helpers for the E1 receive payload and CAS control.
// Assumes a 32-bit APB slave, one register per word, one bank per link.
// Operation
// - Eight link banks, 0x100 register indexes apart
// - Payload read command fills access data register
// - Payload indirect addresses 00-3F, 41-4F, 51-5F
// - Snapshot holds first-frame ABCD while multiframe synced
// - Global trunk enable overrides per-slot ABCD replacement
// - Select 000 uses per-slot select bits 7-5
// - Select 001 sends per-slot data trunk code
// - Select 010 A-law, 011 mu-law milliwatt
// - Master enable gates all payload control
// - Freeze holds stored ABCD values
// - De-bounce needs two identical ABCD codewords
// - Change interrupt when enabled and any flag
// - Busy reads 1 during indirect access
// - Control: direction bit 7, address 6-0
// - Signaling addresses 01-0F and 11-1F
// - Signaling read command fills access data register
// - Change flag set on change, write-1 clears
// - Indication 0: flags 8-1 are slots 8-1
// - Indication 1: flags 15-9, flag 16 slot 17
// - Indication 2: flags 24-17 are slots 25-18
// - Indication 3: flags 30-25 are slots 31-26
package e1rpc_pkg;
  localparam int NUM_LINKS = 8;
  localparam int ADDR_W = 13;
  localparam int IDX_LSB = 2;
  localparam int LINK_LSB = 10;
  localparam int NUM_FLAGS = 30;
  localparam int PC_DEPTH = 128;
  // Register indexes inside one bank
  localparam logic [7:0] IDX_PC_STAT = 8'hCD;
  localparam logic [7:0] IDX_PC_CTRL = 8'hCE;
  localparam logic [7:0] IDX_PC_DATA = 8'hCF;
  localparam logic [7:0] IDX_CFG = 8'hD0;
  localparam logic [7:0] IDX_EN = 8'hD1;
  localparam logic [7:0] IDX_SB_CFG = 8'hD2;
  localparam logic [7:0] IDX_SB_STAT = 8'hD3;
  localparam logic [7:0] IDX_SB_CTRL = 8'hD4;
  localparam logic [7:0] IDX_SB_DATA = 8'hD5;
  localparam logic [7:0] IDX_CHG0 = 8'hD6;
  localparam logic [7:0] IDX_CHG1 = 8'hD7;
  localparam logic [7:0] IDX_CHG2 = 8'hD8;
  localparam logic [7:0] IDX_CHG3 = 8'hD9;
  // Writable bits and reset values
  localparam logic [7:0] CFG_MASK = 8'hC7;
  localparam logic [7:0] EN_MASK = 8'h01;
  localparam logic [7:0] SB_CFG_MASK = 8'h0E;
  localparam logic [7:0] REG_RST = 8'h00;
  // Field positions
  localparam int CFG_SNAP = 7;
  localparam int CFG_GTRK = 6;
  localparam int EN_MASTER = 0;
  localparam int SB_FREEZE = 3;
  localparam int SB_DEB = 2;
  localparam int SB_SIG_CHANGE_IRQ_EN = 1;
  localparam int CTRL_DIR = 7;
  localparam int SLOT_SEL_LSB = 5;
  localparam int SLOT_TRK = 4;
  // Indirect bases and replacement selects
  localparam logic [6:0] SLOT_PAYLOAD_REPLACE_SEL_BASE = 7'h00;
  localparam logic [6:0] DATA_TRUNK_CODE_BASE = 7'h20;
  localparam logic [6:0] SIGC_BASE = 7'h40;
  localparam logic [2:0] SEL_SLOT = 3'h0;
  localparam logic [2:0] SEL_DATA_TRUNK_CODE = 3'h1;
  localparam logic [2:0] SEL_ALAW = 3'h2;
  localparam logic [2:0] SEL_MULAW = 3'h3;
  localparam logic [4:0] TS_ALIGN = 5'h00;
  localparam logic [4:0] TS_CAS = 5'h10;
  localparam logic [7:0] ALAW_MW [8] = '{8'h34, 8'h1D, 8'h1D, 8'h34, 8'hB4, 8'h9D, 8'h9D, 8'hB4};
  localparam logic [7:0] MULAW_MW [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};

  typedef enum logic {ACC_IDLE, ACC_RUN} e1rpc_acc_e;

  function automatic logic reg_known(input logic [7:0] idx);
    return (idx >= IDX_PC_STAT) && (idx <= IDX_CHG3);
  endfunction : reg_known

  function automatic logic pc_addr_ok(input logic [6:0] a);
    return (a <= 7'h3F) || (a >= 7'h41 && a <= 7'h4F) || (a >= 7'h51 && a <= 7'h5F);
  endfunction : pc_addr_ok

  function automatic logic sb_addr_ok(input logic [6:0] a);
    return (a >= 7'h01 && a <= 7'h0F) || (a >= 7'h11 && a <= 7'h1F);
  endfunction : sb_addr_ok

  function automatic logic ts_has_sig(input logic [4:0] ts);
    return (ts != TS_ALIGN) && (ts != TS_CAS);
  endfunction : ts_has_sig

  // Slot 1..15 -> flag bit 0..14, slot 17..31 -> flag bit 15..29
  function automatic logic [4:0] flag_of_ts(input logic [4:0] ts);
    return (ts < TS_CAS) ? ts - 5'h01 : ts - 5'h02;
  endfunction : flag_of_ts

  function automatic logic [6:0] slot_addr(input logic [6:0] base, input logic [4:0] ts);
    return base | {2'b00, ts};
  endfunction : slot_addr
endpackage : e1rpc_pkg

// *** design/e1rpc_sig_filter.sv ***
// CAS signaling store for one link: de-bounce, freeze, snapshot, host port.
// Assumes codewords and frame timeslots arrive on pclk from the framer.
`timescale 1ns/1ps
module e1rpc_sig_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic freeze,
  input wire logic glitch_en,
  input wire logic sig_valid,
  input wire logic [4:0] sig_ts,
  input wire logic [3:0] sig_abcd,
  input wire logic host_we,
  input wire logic [4:0] host_addr,
  input wire logic [3:0] host_data,
  output logic [3:0] host_rdata,
  input wire logic snap_en,
  input wire logic frame_valid,
  input wire logic [4:0] frame_ts,
  input wire logic mf_first,
  output logic [3:0] sig_now,
  output logic change_pulse,
  output logic [4:0] change_ts
);
  logic [3:0] stored [32];
  logic [3:0] last_rx [32];
  logic [3:0] snap [32];
  logic accept;
  logic next_change;

  // Accept a codeword unless frozen or still bouncing
  always_comb begin
    accept = sig_valid && !freeze;
    if (glitch_en && (sig_abcd != last_rx[sig_ts])) accept = 1'b0;
    next_change = accept && (stored[sig_ts] != sig_abcd);
    host_rdata = stored[host_addr];
    sig_now = (snap_en && !mf_first) ? snap[frame_ts] : stored[frame_ts];
  end

  // Signaling stores and change report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        stored[i] <= 4'h0;
        last_rx[i] <= 4'h0;
        snap[i] <= 4'h0;
      end
      change_pulse <= 1'b0;
      change_ts <= 5'h00;
    end else begin
      if (sig_valid) last_rx[sig_ts] <= sig_abcd;
      if (host_we) stored[host_addr] <= host_data;
      else if (accept) stored[sig_ts] <= sig_abcd;
      if (frame_valid && mf_first) snap[frame_ts] <= stored[frame_ts];
      change_pulse <= next_change;
      change_ts <= sig_ts;
    end
  end
endmodule : e1rpc_sig_filter

// *** design/e1rpc_top.sv ***
// APB register banks, indirect access and receive payload control, eight links.
// Assumes framer streams on pclk; host follows the busy handshake.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module e1rpc_top #(
  parameter int NUM_LINKS = e1rpc_pkg::NUM_LINKS,
  parameter int ADDR_W = e1rpc_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NUM_LINKS-1:0] rx_valid,
  input wire logic [NUM_LINKS-1:0][4:0] rx_ts,
  input wire logic [NUM_LINKS-1:0][7:0] rx_byte,
  input wire logic [NUM_LINKS-1:0] rx_sig_valid,
  input wire logic [NUM_LINKS-1:0][3:0] rx_abcd,
  input wire logic [NUM_LINKS-1:0] rx_mf_first,
  input wire logic [NUM_LINKS-1:0] rx_mf_sync,
  output logic [NUM_LINKS-1:0] rx_out_valid,
  output logic [NUM_LINKS-1:0][4:0] rx_out_ts,
  output logic [NUM_LINKS-1:0][7:0] rx_out_byte,
  output logic [NUM_LINKS-1:0][3:0] rx_sig_out,
  output logic [NUM_LINKS-1:0] sig_change_irq
);
  localparam int LW = $clog2(NUM_LINKS);

  // Per-link register state
  logic [7:0] cfg [NUM_LINKS];
  logic [7:0] en [NUM_LINKS];
  logic [7:0] sb_cfg [NUM_LINKS];
  logic [7:0] pc_ctrl [NUM_LINKS];
  logic [7:0] pc_data [NUM_LINKS];
  logic [7:0] sb_ctrl [NUM_LINKS];
  logic [7:0] sb_data [NUM_LINKS];
  e1rpc_pkg::e1rpc_acc_e pc_st [NUM_LINKS];
  e1rpc_pkg::e1rpc_acc_e sb_st [NUM_LINKS];
  logic [e1rpc_pkg::NUM_FLAGS-1:0] flags [NUM_LINKS];
  logic [2:0] mw_ph [NUM_LINKS];
  logic [7:0] pc_mem [NUM_LINKS][e1rpc_pkg::PC_DEPTH];

  logic [7:0] next_cfg [NUM_LINKS];
  logic [7:0] next_en [NUM_LINKS];
  logic [7:0] next_sb_cfg [NUM_LINKS];
  logic [7:0] next_pc_ctrl [NUM_LINKS];
  logic [7:0] next_pc_data [NUM_LINKS];
  logic [7:0] next_sb_ctrl [NUM_LINKS];
  logic [7:0] next_sb_data [NUM_LINKS];
  e1rpc_pkg::e1rpc_acc_e next_pc_st [NUM_LINKS];
  e1rpc_pkg::e1rpc_acc_e next_sb_st [NUM_LINKS];
  logic [e1rpc_pkg::NUM_FLAGS-1:0] next_flags [NUM_LINKS];
  logic [2:0] next_mw_ph [NUM_LINKS];
  logic [NUM_LINKS-1:0] pc_we;
  logic [NUM_LINKS-1:0] sb_we;
  logic [NUM_LINKS-1:0] next_irq;

  // Stream outputs and filter links
  logic [NUM_LINKS-1:0][7:0] next_byte;
  logic [NUM_LINKS-1:0][3:0] next_sig;
  logic [NUM_LINKS-1:0][3:0] sb_rdata;
  logic [NUM_LINKS-1:0][3:0] filt_sig;
  logic [NUM_LINKS-1:0] chg_pulse;
  logic [NUM_LINKS-1:0][4:0] chg_ts;
  logic [NUM_LINKS-1:0] snap_en;

  // APB side
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [7:0] idx;
  logic [LW-1:0] lnk;
  logic wr_go;
  logic rd_ph;
  logic [7:0] rd_val;
  logic [7:0] wd;

  // Decode of the held APB address
  always_comb begin
    idx = paddr[e1rpc_pkg::IDX_LSB +: 8];
    lnk = paddr[e1rpc_pkg::LINK_LSB +: LW];
    wd = pwdata[7:0];
    wr_go = psel && penable && pready && pwrite && e1rpc_pkg::reg_known(idx);
    rd_ph = psel && penable && !pready;
  end

  // Read data mux
  always_comb begin
    rd_val = 8'h00;
    if (idx == e1rpc_pkg::IDX_PC_STAT) begin
      rd_val = {7'h00, pc_st[lnk] == e1rpc_pkg::ACC_RUN};
    end else if (idx == e1rpc_pkg::IDX_PC_CTRL) begin
      rd_val = pc_ctrl[lnk];
    end else if (idx == e1rpc_pkg::IDX_PC_DATA) begin
      rd_val = pc_data[lnk];
    end else if (idx == e1rpc_pkg::IDX_CFG) begin
      rd_val = cfg[lnk];
    end else if (idx == e1rpc_pkg::IDX_EN) begin
      rd_val = en[lnk];
    end else if (idx == e1rpc_pkg::IDX_SB_CFG) begin
      rd_val = sb_cfg[lnk];
    end else if (idx == e1rpc_pkg::IDX_SB_STAT) begin
      rd_val = {7'h00, sb_st[lnk] == e1rpc_pkg::ACC_RUN};
    end else if (idx == e1rpc_pkg::IDX_SB_CTRL) begin
      rd_val = sb_ctrl[lnk];
    end else if (idx == e1rpc_pkg::IDX_SB_DATA) begin
      rd_val = sb_data[lnk];
    end else if (idx == e1rpc_pkg::IDX_CHG0) begin
      rd_val = flags[lnk][7:0];
    end else if (idx == e1rpc_pkg::IDX_CHG1) begin
      rd_val = flags[lnk][15:8];
    end else if (idx == e1rpc_pkg::IDX_CHG2) begin
      rd_val = flags[lnk][23:16];
    end else if (idx == e1rpc_pkg::IDX_CHG3) begin
      rd_val = {2'b00, flags[lnk][29:24]};
    end
  end

  // One wait state: answer registered in the first access cycle
  always_comb begin
    next_pready = rd_ph;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (rd_ph) begin
      next_prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      next_pslverr = !e1rpc_pkg::reg_known(idx);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Direct registers, indirect engines and change flags per link
  always_comb begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      logic hit;
      logic [6:0] pa;
      logic [6:0] sa;
      logic [e1rpc_pkg::NUM_FLAGS-1:0] clr;
      hit = wr_go && (lnk == LW'(l));
      pa = pc_ctrl[l][6:0];
      sa = sb_ctrl[l][6:0];
      clr = '0;
      next_cfg[l] = cfg[l];
      next_en[l] = en[l];
      next_sb_cfg[l] = sb_cfg[l];
      next_pc_ctrl[l] = pc_ctrl[l];
      next_pc_data[l] = pc_data[l];
      next_sb_ctrl[l] = sb_ctrl[l];
      next_sb_data[l] = sb_data[l];
      next_pc_st[l] = pc_st[l];
      next_sb_st[l] = sb_st[l];
      pc_we[l] = 1'b0;
      sb_we[l] = 1'b0;
      if (hit && idx == e1rpc_pkg::IDX_CFG) next_cfg[l] = wd & e1rpc_pkg::CFG_MASK;
      if (hit && idx == e1rpc_pkg::IDX_EN) next_en[l] = wd & e1rpc_pkg::EN_MASK;
      if (hit && idx == e1rpc_pkg::IDX_SB_CFG) next_sb_cfg[l] = wd & e1rpc_pkg::SB_CFG_MASK;
      if (hit && idx == e1rpc_pkg::IDX_CHG0) clr[7:0] = wd;
      if (hit && idx == e1rpc_pkg::IDX_CHG1) clr[15:8] = wd;
      if (hit && idx == e1rpc_pkg::IDX_CHG2) clr[23:16] = wd;
      if (hit && idx == e1rpc_pkg::IDX_CHG3) clr[29:24] = wd[5:0];
      // Payload indirect engine
      case (pc_st[l])
        e1rpc_pkg::ACC_IDLE: begin
          if (hit && idx == e1rpc_pkg::IDX_PC_CTRL) begin
            next_pc_ctrl[l] = wd;
            next_pc_st[l] = e1rpc_pkg::ACC_RUN;
          end else if (hit && idx == e1rpc_pkg::IDX_PC_DATA) begin
            next_pc_data[l] = wd;
          end
        end
        e1rpc_pkg::ACC_RUN: begin
          next_pc_st[l] = e1rpc_pkg::ACC_IDLE;
          if (e1rpc_pkg::pc_addr_ok(pa)) begin
            if (pc_ctrl[l][e1rpc_pkg::CTRL_DIR]) next_pc_data[l] = pc_mem[l][pa];
            else pc_we[l] = 1'b1;
          end
        end
        default: next_pc_st[l] = e1rpc_pkg::ACC_IDLE;
      endcase
      // Signaling buffer indirect engine
      case (sb_st[l])
        e1rpc_pkg::ACC_IDLE: begin
          if (hit && idx == e1rpc_pkg::IDX_SB_CTRL) begin
            next_sb_ctrl[l] = wd;
            next_sb_st[l] = e1rpc_pkg::ACC_RUN;
          end else if (hit && idx == e1rpc_pkg::IDX_SB_DATA) begin
            next_sb_data[l] = wd;
          end
        end
        e1rpc_pkg::ACC_RUN: begin
          next_sb_st[l] = e1rpc_pkg::ACC_IDLE;
          if (e1rpc_pkg::sb_addr_ok(sa)) begin
            if (sb_ctrl[l][e1rpc_pkg::CTRL_DIR]) next_sb_data[l] = {4'h0, sb_rdata[l]};
            else sb_we[l] = 1'b1;
          end
        end
        default: next_sb_st[l] = e1rpc_pkg::ACC_IDLE;
      endcase
      // Clear by write-one first, so a same-cycle change still sets
      next_flags[l] = flags[l] & ~clr;
      if (chg_pulse[l] && e1rpc_pkg::ts_has_sig(chg_ts[l])) begin
        next_flags[l][e1rpc_pkg::flag_of_ts(chg_ts[l])] = 1'b1;
      end
      next_irq[l] = sb_cfg[l][e1rpc_pkg::SB_SIG_CHANGE_IRQ_EN] && (|next_flags[l]);
    end
  end

  // Payload and signaling replacement on the outgoing stream
  always_comb begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      logic [4:0] ts;
      logic [7:0] sub;
      logic [7:0] sigc;
      logic [2:0] sel;
      ts = rx_ts[l];
      sub = pc_mem[l][e1rpc_pkg::slot_addr(e1rpc_pkg::SLOT_PAYLOAD_REPLACE_SEL_BASE, ts)];
      sigc = pc_mem[l][e1rpc_pkg::slot_addr(e1rpc_pkg::SIGC_BASE, ts)];
      sel = cfg[l][2:0];
      if (sel == e1rpc_pkg::SEL_SLOT) sel = sub[e1rpc_pkg::SLOT_SEL_LSB +: 3];
      next_byte[l] = rx_byte[l];
      next_sig[l] = filt_sig[l];
      if (en[l][e1rpc_pkg::EN_MASTER]) begin
        case (sel)
          e1rpc_pkg::SEL_DATA_TRUNK_CODE: begin
            next_byte[l] = pc_mem[l][e1rpc_pkg::slot_addr(e1rpc_pkg::DATA_TRUNK_CODE_BASE, ts)];
          end
          e1rpc_pkg::SEL_ALAW: next_byte[l] = e1rpc_pkg::ALAW_MW[mw_ph[l]];
          e1rpc_pkg::SEL_MULAW: next_byte[l] = e1rpc_pkg::MULAW_MW[mw_ph[l]];
          default: next_byte[l] = rx_byte[l];
        endcase
        if (e1rpc_pkg::ts_has_sig(ts) &&
            (cfg[l][e1rpc_pkg::CFG_GTRK] || sigc[e1rpc_pkg::SLOT_TRK])) begin
          next_sig[l] = sigc[3:0];
        end
      end
      next_mw_ph[l] = mw_ph[l];
      if (rx_valid[l] && ts == e1rpc_pkg::TS_ALIGN) next_mw_ph[l] = mw_ph[l] + 3'h1;
      snap_en[l] = cfg[l][e1rpc_pkg::CFG_SNAP] && rx_mf_sync[l] &&
                   en[l][e1rpc_pkg::EN_MASTER];
    end
  end

  // Register all per-link state except the payload store, and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        cfg[l] <= e1rpc_pkg::REG_RST;
        en[l] <= e1rpc_pkg::REG_RST;
        sb_cfg[l] <= e1rpc_pkg::REG_RST;
        pc_ctrl[l] <= e1rpc_pkg::REG_RST;
        pc_data[l] <= e1rpc_pkg::REG_RST;
        sb_ctrl[l] <= e1rpc_pkg::REG_RST;
        sb_data[l] <= e1rpc_pkg::REG_RST;
        pc_st[l] <= e1rpc_pkg::ACC_IDLE;
        sb_st[l] <= e1rpc_pkg::ACC_IDLE;
        flags[l] <= '0;
        mw_ph[l] <= 3'h0;
      end
      rx_out_valid <= '0;
      rx_out_ts <= '0;
      rx_out_byte <= '0;
      rx_sig_out <= '0;
      sig_change_irq <= '0;
    end else begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        cfg[l] <= next_cfg[l];
        en[l] <= next_en[l];
        sb_cfg[l] <= next_sb_cfg[l];
        pc_ctrl[l] <= next_pc_ctrl[l];
        pc_data[l] <= next_pc_data[l];
        sb_ctrl[l] <= next_sb_ctrl[l];
        sb_data[l] <= next_sb_data[l];
        pc_st[l] <= next_pc_st[l];
        sb_st[l] <= next_sb_st[l];
        flags[l] <= next_flags[l];
        mw_ph[l] <= next_mw_ph[l];
      end
      rx_out_valid <= rx_valid;
      rx_out_ts <= rx_ts;
      rx_out_byte <= next_byte;
      rx_sig_out <= next_sig;
      sig_change_irq <= next_irq;
    end
  end

  // Payload indirect storage, written only by its engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        for (int a = 0; a < e1rpc_pkg::PC_DEPTH; a++) pc_mem[l][a] <= 8'h00;
      end
    end else begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        if (pc_we[l]) pc_mem[l][pc_ctrl[l][6:0]] <= pc_data[l];
      end
    end
  end

  // One CAS store per link
  for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link
    e1rpc_sig_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .freeze(sb_cfg[g][e1rpc_pkg::SB_FREEZE]),
      .glitch_en(sb_cfg[g][e1rpc_pkg::SB_DEB]),
      .sig_valid(rx_sig_valid[g]),
      .sig_ts(rx_ts[g]),
      .sig_abcd(rx_abcd[g]),
      .host_we(sb_we[g]),
      .host_addr(sb_ctrl[g][4:0]),
      .host_data(sb_data[g][3:0]),
      .host_rdata(sb_rdata[g]),
      .snap_en(snap_en[g]),
      .frame_valid(rx_valid[g]),
      .frame_ts(rx_ts[g]),
      .mf_first(rx_mf_first[g]),
      .sig_now(filt_sig[g]),
      .change_pulse(chg_pulse[g]),
      .change_ts(chg_ts[g])
    );
  end
endmodule : e1rpc_top

// *** tb/e1rpc_framer.sv ***
// Framer source model: one timeslot per cycle on every link, CAS per slot.
// Assumes the bench sets run, the target slot and its ABCD codeword.
`timescale 1ns/1ps
module e1rpc_framer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [4:0] tgt_ts,
  input wire logic [3:0] tgt_abcd,
  output logic [7:0] rx_valid,
  output logic [7:0][4:0] rx_ts,
  output logic [7:0][7:0] rx_byte,
  output logic [7:0] rx_sig_valid,
  output logic [7:0][3:0] rx_abcd,
  output logic [7:0] rx_mf_first,
  output logic [7:0] rx_mf_sync
);
  logic [4:0] ts;
  logic [3:0] fr;
  // Slot and frame counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts <= 5'h00;
      fr <= 4'h0;
    end else if (run) begin
      ts <= ts + 5'h01;
      fr <= fr + {3'h0, ts == 5'h1F};
    end
  end
  // Same stream on all links; slots 0 and 16 carry no codeword
  assign rx_valid = {8{run}};
  assign rx_ts = {8{ts}};
  assign rx_byte = {8{{3'h0, ts} ^ 8'h55}};
  assign rx_sig_valid = {8{run && ts != 5'h00 && ts != 5'h10}};
  assign rx_abcd = {8{(ts == tgt_ts) ? tgt_abcd : 4'h0}};
  assign rx_mf_first = {8{fr == 4'h0}};
  assign rx_mf_sync = 8'hFF;
endmodule : e1rpc_framer

// *** tb/e1rpc_props.sv ***
// Checker on e1rpc_top ports: APB handshake, error reply, stream lag.
// Bound to every e1rpc_top instance at the foot of this file.
`timescale 1ns/1ps
module e1rpc_props #(
  parameter int NUM_LINKS = 8,
  parameter int ADDR_W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [NUM_LINKS-1:0] rx_valid,
  input wire logic [NUM_LINKS-1:0] rx_out_valid,
  input wire logic [NUM_LINKS-1:0] sig_change_irq
);
  logic bad_idx;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Index outside the known registers CD-D9 of a bank
  assign bad_idx = (paddr[9:2] < 8'hCD) || (paddr[9:2] > 8'hD9);
  a_one_wait: assert property (
    psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("not one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_bad_idx: assert property (pready |-> pslverr == bad_idx)
    else $error("pslverr wrong for index");
  a_err_no_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("data on error reply");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_busy_bit_only: assert property (pready && !pwrite &&
    (paddr[9:2] == 8'hCD || paddr[9:2] == 8'hD3) |-> prdata[7:1] == 7'h0)
    else $error("status reserved bits set");
  a_out_lag: assert property (rx_out_valid == $past(rx_valid))
    else $error("stream out not one cycle late");
  a_irq_quiet: assert property ($rose(presetn) |-> sig_change_irq == '0)
    else $error("irq high after reset");
  c_err: cover property (pready && pslverr);
  c_ctrl: cover property (pready && pwrite && paddr[9:2] == 8'hD4);
  c_irq: cover property (|sig_change_irq);
endmodule : e1rpc_props
bind e1rpc_top e1rpc_props #(.NUM_LINKS(NUM_LINKS), .ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_out_valid(rx_out_valid), .sig_change_irq(sig_change_irq));

// *** tb/test_e1rpc_top.sv ***
// Bench for e1rpc_top: registers, indirect access, payload and CAS flags.
// Assumes the framer model feeds every link; link 0 is observed.
`timescale 1ns/1ps
module test_e1rpc_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, rerr;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] tgt_ts;
  logic [3:0] tgt_abcd;
  logic [7:0] rx_valid, rx_sig_valid, rx_mf_first, rx_mf_sync, rx_out_valid, sig_change_irq;
  logic [7:0][4:0] rx_ts, rx_out_ts;
  logic [7:0][7:0] rx_byte, rx_out_byte;
  logic [7:0][3:0] rx_abcd, rx_sig_out;
  logic [7:0] ob [32];
  logic [3:0] os [32];
  logic [7:0] rdat;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  e1rpc_framer u_framer (.pclk(pclk), .presetn(presetn), .run(run), .tgt_ts(tgt_ts),
    .tgt_abcd(tgt_abcd), .rx_valid(rx_valid), .rx_ts(rx_ts), .rx_byte(rx_byte),
    .rx_sig_valid(rx_sig_valid), .rx_abcd(rx_abcd), .rx_mf_first(rx_mf_first),
    .rx_mf_sync(rx_mf_sync));
  e1rpc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_ts(rx_ts), .rx_byte(rx_byte),
    .rx_sig_valid(rx_sig_valid), .rx_abcd(rx_abcd), .rx_mf_first(rx_mf_first),
    .rx_mf_sync(rx_mf_sync), .rx_out_valid(rx_out_valid), .rx_out_ts(rx_out_ts),
    .rx_out_byte(rx_out_byte), .rx_sig_out(rx_sig_out), .sig_change_irq(sig_change_irq));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Cuts a hung run short; captures link 0 output per slot
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rx_out_valid[0]) begin
      ob[rx_out_ts[0]] <= rx_out_byte[0];
      os[rx_out_ts[0]] <= rx_sig_out[0];
    end
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer after an idle edge
  task automatic apb(input logic w, input logic [2:0] ln, input logic [7:0] ix,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ln, ix, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 40) chk(8'h00, 8'hFF);
  endtask : apb
  task automatic rdc(input logic [2:0] ln, input logic [7:0] ix, input logic [7:0] exp);
    apb(1'b0, ln, ix, 8'h00);
    chk(rdat, exp);
  endtask : rdc
  // Indirect command on link 0, ci is the control index
  task automatic ind(input logic [7:0] ci, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    if (!a[7]) apb(1'b1, 3'h0, 8'(ci + 1), d); // Data first
    apb(1'b1, 3'h0, ci, a);
    do begin
      apb(1'b0, 3'h0, 8'(ci - 1), 8'h00);
      n++;
    end while (rdat[0] !== 1'b0 && n < 20); // Wait out busy
    chk({7'h0, rdat[0]}, 8'h00);
  endtask : ind
  task automatic frames();
    repeat (70) @(posedge pclk);
  endtask : frames
  function automatic logic [7:0] in_mw(input logic [7:0] b, input logic mu);
    in_mw = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b === (mu ? e1rpc_pkg::MULAW_MW[i] : e1rpc_pkg::ALAW_MW[i])) in_mw = 8'h01;
    end
  endfunction : in_mw

  task automatic t_regs();
    for (int i = 8'hD0; i <= 8'hD9; i++) rdc(3'h0, 8'(i), 8'h00);
    apb(1'b1, 3'h0, 8'hD0, 8'hFF);
    rdc(3'h0, 8'hD0, 8'hC7);
    apb(1'b1, 3'h0, 8'hD1, 8'hFF);
    rdc(3'h0, 8'hD1, 8'h01);
    apb(1'b1, 3'h7, 8'hD4, 8'hA5);
    rdc(3'h7, 8'hD4, 8'hA5);
    rdc(3'h7, 8'hD0, 8'h00);
    rdc(3'h0, 8'hD4, 8'h00);
    apb(1'b0, 3'h0, 8'hE0, 8'h00);
    chk({7'h0, rerr}, 8'h01);
    apb(1'b1, 3'h0, 8'hD0, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_indirect();
    ind(8'hCE, 8'h25, 8'h5A);
    ind(8'hCE, 8'h5F, 8'h33);
    ind(8'hCE, 8'hA5, 8'h00);
    rdc(3'h0, 8'hCF, 8'h5A);
    ind(8'hCE, 8'hD0, 8'h00);
    rdc(3'h0, 8'hCF, 8'h5A);
    ind(8'hCE, 8'hDF, 8'h00);
    rdc(3'h0, 8'hCF, 8'h33);
    ind(8'hD4, 8'h1F, 8'hFA);
    ind(8'hD4, 8'h9F, 8'h00);
    rdc(3'h0, 8'hD5, 8'h0A);
    ind(8'hD4, 8'h90, 8'h00);
    rdc(3'h0, 8'hD5, 8'h0A);
    ind(8'hD4, 8'h1F, 8'h00);
    $display("test indirect done");
  endtask : t_indirect
  task automatic t_payload();
    ind(8'hCE, 8'h25, 8'h3C);
    apb(1'b1, 3'h0, 8'hD0, 8'h01);
    frames();
    chk(ob[5], 8'h3C);
    apb(1'b1, 3'h0, 8'hD0, 8'h00);
    ind(8'hCE, 8'h05, 8'h20);
    frames();
    chk(ob[5], 8'h3C);
    chk(ob[6], 8'h53);
    for (int s = 2; s < 4; s++) begin
      apb(1'b1, 3'h0, 8'hD0, 8'(s));
      frames();
      chk(in_mw(ob[5], s[0]), 8'h01);
    end
    apb(1'b1, 3'h0, 8'hD1, 8'h00);
    frames();
    chk(ob[5], 8'h50);
    apb(1'b1, 3'h0, 8'hD1, 8'h01);
    apb(1'b1, 3'h0, 8'hD0, 8'h40);
    ind(8'hCE, 8'h45, 8'h09);
    frames();
    chk({4'h0, os[5]}, 8'h09);
    apb(1'b1, 3'h0, 8'hD0, 8'h00);
    ind(8'hCE, 8'h45, 8'h19);
    ind(8'hCE, 8'h46, 8'h07);
    frames();
    chk({4'h0, os[5]}, 8'h09);
    chk({4'h0, os[6]}, 8'h00);
    $display("test payload done");
  endtask : t_payload
  task automatic t_cas();
    int tsl[9] = '{1, 8, 9, 15, 17, 18, 25, 26, 31};
    int f;
    apb(1'b1, 3'h0, 8'hD2, 8'h0A);
    tgt_ts <= 5'd3;
    tgt_abcd <= 4'h5;
    frames();
    rdc(3'h0, 8'hD6, 8'h00);
    apb(1'b1, 3'h0, 8'hD2, 8'h00);
    frames();
    rdc(3'h0, 8'hD6, 8'h04);
    chk({7'h0, sig_change_irq[0]}, 8'h00);
    apb(1'b1, 3'h0, 8'hD2, 8'h06);
    for (int i = 0; i < 9; i++) begin
      tgt_abcd <= 4'h0;
      frames();
      apb(1'b1, 3'h0, 8'hD6, 8'hFF);
      f = (tsl[i] < 16) ? tsl[i] - 1 : tsl[i] - 2;
      tgt_ts <= 5'(tsl[i]);
      tgt_abcd <= 4'h5;
      frames();
      rdc(3'h0, 8'(8'hD6 + f / 8), 8'(1 << (f % 8)));
      chk({7'h0, sig_change_irq[0]}, 8'h01);
      tgt_abcd <= 4'h0;
      frames();
      apb(1'b1, 3'h0, 8'(8'hD6 + f / 8), 8'hFF);
      tgt_abcd <= 4'h5;
      repeat (32) @(posedge pclk);
      tgt_abcd <= 4'h0;
      frames();
      rdc(3'h0, 8'(8'hD6 + f / 8), 8'h00);
      chk({7'h0, sig_change_irq[0]}, 8'h00);
    end
    $display("test cas done");
  endtask : t_cas
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Reset, then the scenarios in turn
  initial begin
    {psel, penable, pwrite, run, paddr, pwdata, tgt_ts, tgt_abcd} = 58'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_indirect();
    run <= 1'b1;
    t_payload();
    t_cas();
    stop_test();
  end
endmodule : test_e1rpc_top
